// file: verilog/tsa_core.sv
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Operation
// RL1: Eight-bit settings register, fields, reset zero.
// RL2: Resolution field selects 9 to 12 bits.
// RL3: Fault queue field selects 1,2,4,6 conversions.
// RL4: Polarity bit: one high, zero low.
// RL5: Mode bit: one interrupt, zero comparator.
// RL6: Shutdown halts conversions, register port stays.
// RL7: Registers stay accessible during shutdown.
// RL8: Host writes shutdown, then shutdown plus single-shot.
// RL9: Single-shot converts once, clears bit, stays shut.
// RL10: Comparator: set above upper, clear below lower.
// RL11: Comparator alert survives shutdown, clears while converting; the code clears it in continuous conversion only, never on a single shot.
// RL12: Interrupt set above upper, any read clears.
// RL13: After cleared, below lower raises next interrupt.
// RL14: Entering shutdown clears interrupt-mode alert.
// RL15: Assert only after queue count above upper.
// RL16: Same queue count below lower required.
// RL17: Conversion lasts 30, 60, 120, 240 ms.
// RL18: Power-on defaults for all registers.
// RL19: Two ms delay, then defaults and conversion.
// RL20: Reading left aligned, unused bits zero.
// RL21: Limits use upper nine bits only.
// RL22: Compare and count once per conversion.
module tsa_core
  import tsa_pkg::*;
#(
  parameter int CONV_BASE_CYC = CONV_9B_CYC, // Cycles of a 9-bit conversion.
  parameter int PWRUP_CYC     = POWERUP_CYC  // Cycles of the power-up delay.
) (
  input  wire logic        core_clk_i,    // 250 MHz clock.
  input  wire logic        reset_n_i,     // Synchronous reset, active low.
  input  wire tsa_req_s    req_i,         // Register port request.
  input  wire logic [15:0] temp_sample_i, // Sensor value, 12-bit left aligned.
  output logic      [15:0] rd_data_o,     // Read data, cycle after read.
  output logic             alert_o,       // Alert pin level.
  output logic             converting_o   // A conversion is running.
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Fault queue depth from its two-bit field.
  function automatic logic [2:0] queue_depth(input logic [1:0] f);
    case (f)
      2'b00:   queue_depth = 3'h1; // RL3
      2'b01:   queue_depth = 3'h2;
      2'b10:   queue_depth = 3'h4;
      default: queue_depth = 3'h6;
    endcase
  endfunction : queue_depth

  // Conversion length doubles with each extra bit of resolution.
  function automatic logic [31:0] conv_cycles(input logic [1:0] r);
    conv_cycles = 32'(CONV_BASE_CYC) << r; // RL17 RL2
  endfunction : conv_cycles

  // Bits kept in the reading for a resolution of 9 to 12 bits.
  function automatic logic [15:0] res_mask(input logic [1:0] r);
    res_mask = 16'(READ_MASK12 << (2'h3 - r)); // RL20 RL2
  endfunction : res_mask

  // Saturating counter step for the fault queues.
  function automatic logic [2:0] q_step(input logic hit,
                                        input logic [2:0] c);
    if (!hit) begin
      q_step = 3'h0;
    end else if (c >= FQ_SAT) begin
      q_step = FQ_SAT;
    end else begin
      q_step = 3'(c + 3'h1);
    end
  endfunction : q_step

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  tsa_regs_s   s_r;
  tsa_regs_s   s_nxt;
  logic [15:0] sample_q;
  logic        over_lim;
  logic        under_lim;
  logic        conv_done;
  logic        start_conv;
  logic        shdn_entry;
  logic [2:0]  depth;
  logic        hi_met;
  logic        lo_met;

  // Limits compare on whole reading in 1/16 degree; limits keep only
  // the nine upper bits, so their low three nibble bits become zero.
  assign sample_q  = temp_sample_i & res_mask(s_r.settings[6:5]);
  assign over_lim  = $signed(sample_q[15:4]) >
                     $signed({s_r.upper[15:7], 3'b000}); // RL21 RL10
  assign under_lim = $signed(sample_q[15:4]) <
                     $signed({s_r.lower[15:7], 3'b000}); // RL21 RL10
  assign conv_done = (s_r.st == ST_CONV) &&
                     (s_r.timer >= conv_cycles(s_r.settings[6:5]) - 32'h1);
  assign depth     = queue_depth(s_r.settings[SET_FQ_HI:SET_FQ_LO]);
  assign shdn_entry = req_i.wr && (req_i.addr == REG_SETTINGS) &&
                      req_i.wdata[SET_SHDN] && !s_r.settings[SET_SHDN];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    start_conv = 1'b0;
    hi_met     = 1'b0;
    lo_met     = 1'b0;

    // Register writes; the reading register ignores writes.
    if (req_i.wr) begin // RL7
      case (req_i.addr)
        REG_SETTINGS: s_nxt.settings = req_i.wdata[7:0]; // RL1
        REG_LOWER:    s_nxt.lower    = req_i.wdata & LIMIT_MASK; // RL21
        REG_UPPER:    s_nxt.upper    = req_i.wdata & LIMIT_MASK; // RL21
        REG_POINTER:  s_nxt.pointer  = req_i.wdata[7:0];
        default:      s_nxt.pointer  = s_r.pointer;
      endcase
    end

    // Read data; unmapped indices read as zero.
    if (req_i.rd) begin
      case (req_i.addr)
        REG_READING:  s_nxt.rdata = s_r.reading;
        REG_SETTINGS: s_nxt.rdata = {8'h00, s_r.settings};
        REG_LOWER:    s_nxt.rdata = s_r.lower;
        REG_UPPER:    s_nxt.rdata = s_r.upper;
        REG_POINTER:  s_nxt.rdata = {8'h00, s_r.pointer};
        default:      s_nxt.rdata = 16'h0000;
      endcase
    end

    // Clears come first so that a same-cycle alert event wins.
    if (s_r.settings[SET_MODE]) begin
      if (req_i.rd) begin
        s_nxt.alert_act = 1'b0; // RL12 RL13
      end
      if (shdn_entry) begin
        s_nxt.alert_act = 1'b0; // RL14
      end
    end

    case (s_r.st)
      ST_POWERUP: begin
        s_nxt.timer = s_r.timer + 32'h1;
        if (s_r.timer >= 32'(PWRUP_CYC) - 32'h1) begin // RL19
          s_nxt.settings = RST_SETTINGS; // RL18
          s_nxt.reading  = RST_READING;
          s_nxt.upper    = RST_UPPER;
          s_nxt.lower    = RST_LOWER;
          s_nxt.pointer  = RST_POINTER;
          s_nxt.st       = ST_CONV;
          s_nxt.timer    = 32'h0;
          s_nxt.one_shot = 1'b0;
        end
      end
      ST_IDLE: begin
        // Shutdown leaves only on a cleared shutdown bit or a shot.
        if (!s_nxt.settings[SET_SHDN]) begin // RL6
          start_conv     = 1'b1;
          s_nxt.one_shot = 1'b0;
        end else if (s_nxt.settings[SET_ONESHOT]) begin // RL9
          start_conv     = 1'b1;
          s_nxt.one_shot = 1'b1;
        end
        if (start_conv) begin
          s_nxt.st    = ST_CONV;
          s_nxt.timer = 32'h0;
        end
      end
      ST_CONV: begin
        s_nxt.timer = s_r.timer + 32'h1;
        if (conv_done) begin // RL22
          s_nxt.reading = sample_q; // RL20
          s_nxt.hi_cnt  = q_step(over_lim, s_r.hi_cnt); // RL15
          s_nxt.lo_cnt  = q_step(under_lim, s_r.lo_cnt); // RL16
          hi_met = over_lim && (s_nxt.hi_cnt >= depth); // RL15
          lo_met = under_lim && (s_nxt.lo_cnt >= depth); // RL16
          s_nxt.timer = 32'h0;
          if (s_r.one_shot) begin
            // A host write in the same cycle keeps its own bit 7.
            if (!(req_i.wr && req_i.addr == REG_SETTINGS)) begin
              s_nxt.settings[SET_ONESHOT] = 1'b0; // RL9
            end
            s_nxt.st = ST_IDLE;
          end else if (s_nxt.settings[SET_SHDN]) begin
            s_nxt.st = ST_IDLE; // RL6
          end
        end else if (!s_r.one_shot && s_nxt.settings[SET_SHDN]) begin
          // A partial conversion is thrown away on shutdown.
          s_nxt.st    = ST_IDLE; // RL6
          s_nxt.timer = 32'h0;
        end
      end
      default: begin
        s_nxt.st = ST_POWERUP;
      end
    endcase

    // Alert decisions, taken only at the end of a conversion.
    if (s_r.settings[SET_MODE]) begin // RL5
      if (!s_r.wait_low && hi_met) begin
        s_nxt.alert_act = 1'b1; // RL12
        s_nxt.wait_low  = 1'b1;
      end else if (s_r.wait_low && lo_met) begin
        s_nxt.alert_act = 1'b1; // RL13 RL16
        s_nxt.wait_low  = 1'b0;
      end
    end else begin
      if (!s_r.alert_act && hi_met) begin
        s_nxt.alert_act = 1'b1; // RL10
      end else if (s_r.alert_act && lo_met && !s_r.one_shot) begin
        s_nxt.alert_act = 1'b0; // RL11
      end
    end

    s_nxt.alert_pin = ~(s_nxt.alert_act ^ s_nxt.settings[SET_POL]); // RL4
    s_nxt.busy      = (s_nxt.st == ST_CONV);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------

  // Reset holds the pin inactive for the active-low default.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s_r.st        <= ST_POWERUP;
      s_r.timer     <= 32'h0;
      s_r.one_shot  <= 1'b0;
      s_r.settings  <= RST_SETTINGS; // RL1 RL18
      s_r.reading   <= RST_READING;
      s_r.upper     <= RST_UPPER;
      s_r.lower     <= RST_LOWER;
      s_r.pointer   <= RST_POINTER;
      s_r.hi_cnt    <= 3'h0;
      s_r.lo_cnt    <= 3'h0;
      s_r.alert_act <= 1'b0;
      s_r.wait_low  <= 1'b0;
      s_r.alert_pin <= 1'b1;
      s_r.busy      <= 1'b0;
      s_r.rdata     <= 16'h0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data_o    = s_r.rdata;
  assign alert_o      = s_r.alert_pin;
  assign converting_o = s_r.busy;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_shot_done;
    conv_done && s_r.one_shot && !req_i.wr;
  endsequence

  property p_shot_clears;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_shot_done |=> !s_r.settings[7] && (s_r.st == ST_IDLE);
  endproperty
  a_shot_clears: assert property (p_shot_clears) // RL9
    else $error("single shot did not clear and stop");

  property p_polarity;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_r.st != ST_POWERUP |->
        alert_o == (s_r.alert_act == s_r.settings[2]);
  endproperty
  a_polarity: assert property (p_polarity) // RL4
    else $error("alert pin level disagrees with polarity");

  property p_shdn_hold;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_r.st == ST_IDLE) ##1 (s_r.st == ST_IDLE) |-> $stable(s_r.reading);
  endproperty
  a_shdn_hold: assert property (p_shdn_hold) // RL6
    else $error("reading changed during shutdown");

  property p_read_clears;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_r.settings[1] && req_i.rd && !conv_done |=> !s_r.alert_act;
  endproperty
  a_read_clears: assert property (p_read_clears) // RL12
    else $error("read did not clear interrupt");

  property p_shdn_int_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_r.settings[1] && shdn_entry && !conv_done |=> !s_r.alert_act;
  endproperty
  a_shdn_int_clear: assert property (p_shdn_int_clear) // RL14
    else $error("shutdown entry did not clear interrupt");

  property p_cmp_set;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !s_r.settings[1] && conv_done && over_lim &&
      (q_step(1'b1, s_r.hi_cnt) >= depth) |=> s_r.alert_act;
  endproperty
  a_cmp_set: assert property (p_cmp_set) // RL15
    else $error("comparator alert not raised after queue");

  sequence s_cmp_idle_on;
    (s_r.st == ST_IDLE) && !s_r.settings[1] && s_r.alert_act &&
      !req_i.wr;
  endsequence

  property p_cmp_keep;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_cmp_idle_on |=> s_r.alert_act;
  endproperty
  a_cmp_keep: assert property (p_cmp_keep) // RL11
    else $error("comparator alert dropped in shutdown");

  property p_read_zero_bits;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_r.st == ST_CONV) ##1 $changed(s_r.reading) |->
        (s_r.reading & ~res_mask($past(s_r.settings[6:5]))) == 16'h0000;
  endproperty
  a_read_zero_bits: assert property (p_read_zero_bits) // RL20
    else $error("reading holds bits below resolution");

  property p_pwrup_defaults;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_r.st == ST_POWERUP) && (s_r.timer == 32'(PWRUP_CYC) - 32'h1) |=>
        (s_r.st == ST_CONV) && (s_r.upper == RST_UPPER) &&
        (s_r.lower == RST_LOWER) && (s_r.settings == RST_SETTINGS);
  endproperty
  a_pwrup_defaults: assert property (p_pwrup_defaults) // RL18
    else $error("power-up defaults or start missing");

  // Queue rules: no alert before the count, clear and re-arm after it.
  sequence s_cmp_early;
    !s_r.settings[SET_MODE] && !s_r.alert_act && conv_done &&
      over_lim && (q_step(1'b1, s_r.hi_cnt) < depth);
  endsequence

  property p_cmp_early;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_cmp_early |=> !s_r.alert_act;
  endproperty
  a_cmp_early: assert property (p_cmp_early) // RL15
    else $error("comparator alert raised before queue filled");

  property p_cmp_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !s_r.settings[SET_MODE] && s_r.alert_act && !s_r.one_shot &&
      conv_done && under_lim && (q_step(1'b1, s_r.lo_cnt) >= depth) |=>
        !s_r.alert_act;
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) // RL16
    else $error("comparator alert not cleared after queue");

  property p_int_low;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_r.settings[SET_MODE] && s_r.wait_low && conv_done && under_lim &&
      (q_step(1'b1, s_r.lo_cnt) >= depth) |=>
        s_r.alert_act && !s_r.wait_low;
  endproperty
  a_int_low: assert property (p_int_low) // RL13
    else $error("no interrupt after queue below lower limit");

  // Power-up wait and shutdown both keep the converter idle; a write in
  // the same cycle is left out of the shutdown check since it may start a shot.
  property p_pwrup_wait;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_r.st == ST_POWERUP) && (s_r.timer < 32'(PWRUP_CYC) - 32'h1) |=>
        (s_r.st == ST_POWERUP) && !converting_o;
  endproperty
  a_pwrup_wait: assert property (p_pwrup_wait) // RL19
    else $error("conversion started before power-up delay");

  property p_shdn_halt;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (s_r.st == ST_IDLE) && s_r.settings[SET_SHDN] &&
      !s_r.settings[SET_ONESHOT] && !req_i.wr |=> !converting_o;
  endproperty
  a_shdn_halt: assert property (p_shdn_halt) // RL6
    else $error("conversion started while shut down");

endmodule : tsa_core

// file: verilog/tsa_pkg.sv
package tsa_pkg;

  // ---------------------------------------------------------------
  // Register indices on the plain register port
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_READING  = 3'h0;
  localparam logic [2:0] REG_SETTINGS = 3'h1;
  localparam logic [2:0] REG_LOWER    = 3'h2;
  localparam logic [2:0] REG_UPPER    = 3'h3;
  localparam logic [2:0] REG_POINTER  = 3'h4;

  // ---------------------------------------------------------------
  // Settings field positions
  // ---------------------------------------------------------------
  localparam int SET_ONESHOT = 7;
  localparam int SET_RES_HI  = 6;
  localparam int SET_RES_LO  = 5;
  localparam int SET_FQ_HI   = 4;
  localparam int SET_FQ_LO   = 3;
  localparam int SET_POL     = 2;
  localparam int SET_MODE    = 1;
  localparam int SET_SHDN    = 0;

  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_SETTINGS = 8'h00;
  localparam logic [15:0] RST_READING  = 16'h0000;
  localparam logic [15:0] RST_UPPER    = 16'ha000;
  localparam logic [15:0] RST_LOWER    = 16'h9600;
  localparam logic [7:0]  RST_POINTER  = 8'h00;
  localparam logic [15:0] LIMIT_MASK   = 16'hff80;
  localparam logic [15:0] READ_MASK12  = 16'hfff0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 250;
  localparam int CONV_9B_MS    = 30;
  localparam int POWERUP_MS    = 2;
  localparam int CONV_9B_CYC   = CONV_9B_MS * CLK_MHZ * 1000;
  localparam int POWERUP_CYC   = POWERUP_MS * CLK_MHZ * 1000;
  localparam logic [2:0] FQ_SAT = 3'h6;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b001,
    ST_IDLE    = 3'b010,
    ST_CONV    = 3'b100
  } tsa_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } tsa_req_s;

  typedef struct packed {
    tsa_state_e  st;
    logic [31:0] timer;
    logic        one_shot;
    logic [7:0]  settings;
    logic [15:0] reading;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [7:0]  pointer;
    logic [2:0]  hi_cnt;
    logic [2:0]  lo_cnt;
    logic        alert_act;
    logic        wait_low;
    logic        alert_pin;
    logic        busy;
    logic [15:0] rdata;
  } tsa_regs_s;

endpackage : tsa_pkg

// file: testbench/tsa_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host on the register port
// ---------------------------------------------------------------
module tsa_host_model
  import tsa_pkg::*;
(
  input  wire logic        core_clk_i,   // Bench clock.
  input  wire logic [15:0] rd_data_i,    // Read data from the block.
  input  wire logic        converting_i, // A conversion is running.
  output tsa_req_s         req_o         // Register port request.
);

  // The port is quiet until the first task call.
  initial req_o = '0;

  // A write is one strobe cycle, changed only right after an edge.
  task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    req_o <= '0;
  endtask : reg_wr

  // Read data change only at the edge that accepts a read strobe and then
  // hold, so take them just after the edge that accepted the strobe.
  task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk_i);
    req_o <= '0;
    #1;
    d = rd_data_i;
  endtask : reg_rd

  // One measurement: park in shutdown first, then request the shot.
  // Returns the number of cycles that the conversion ran.
  task automatic shot(input logic [7:0] s, output int n);
    reg_wr(REG_SETTINGS, {8'h00, s | 8'h01});
    reg_wr(REG_SETTINGS, {8'h00, s | 8'h81});
    // The first cycle of the conversion is the one right after the
    // strobe edge, so look before waiting for the next edge.
    n = 0;
    repeat (3000) begin
      #1;
      if (converting_i) n++;
      else if (n > 0) break;
      @(posedge core_clk_i);
    end
  endtask : shot

endmodule : tsa_host_model

// file: testbench/test_temp_sensor_config_alert.sv
`timescale 1ns/1ps
module test_temp_sensor_config_alert
  import tsa_pkg::*;
;
  // Short counts keep the run brief; expectations derive from these.
  localparam int CONV = 8;
  localparam int PWR  = 4;

  logic        core_clk;
  logic        reset_n;
  tsa_req_s    req;
  logic [15:0] temp_sample;
  logic [15:0] rd_data;
  logic        alert;
  logic        converting;
  int          fail_count  = 0;
  int          checks_done = 0;
  logic [15:0] v;
  int          n;
  logic [7:0]  s;
  int          qdep [4] = '{1, 2, 4, 6};

  // 250 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  tsa_core #(.CONV_BASE_CYC(CONV), .PWRUP_CYC(PWR)) dut_u (
    .core_clk_i    (core_clk),
    .reset_n_i     (reset_n),
    .req_i         (req),
    .temp_sample_i (temp_sample),
    .rd_data_o     (rd_data),
    .alert_o       (alert),
    .converting_o  (converting)
  );

  tsa_host_model host_u (
    .core_clk_i   (core_clk),
    .rd_data_i    (rd_data),
    .converting_i (converting),
    .req_o        (req)
  );

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic rdchk(input string nm, input logic [2:0] a,
                       input logic [15:0] exp);
    host_u.reg_rd(a, v);
    check(nm, v, exp);
  endtask : rdchk

  task automatic chk_alert(input logic e);
    check("alert", {15'h0000, alert}, {15'h0000, e});
  endtask : chk_alert

  // The sensor input moves only on a rising edge.
  task automatic set_temp(input logic [15:0] t);
    @(posedge core_clk);
    temp_sample <= t;
  endtask : set_temp

  task automatic done_test(input string nm);
    $display("test %s done, mismatches so far %0d", nm, fail_count);
  endtask : done_test

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // The whole run needs about a thousand cycles; this limit cuts a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    reset_n     <= 1'b0;
    temp_sample <= 16'h0000;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    // Writes made during the power-up delay are wiped, so wait it out.
    repeat (PWR + 4) @(posedge core_clk);
    #1;
    chk_alert(1'b1);
    check("running", {15'h0000, converting}, 16'h0001);
    rdchk("settings", REG_SETTINGS, 16'h0000);
    rdchk("upper", REG_UPPER, 16'ha000);
    rdchk("lower", REG_LOWER, 16'h9600);
    rdchk("reading", REG_READING, 16'h0000);
    rdchk("pointer", REG_POINTER, 16'h0000);
    done_test("defaults");

    host_u.reg_wr(REG_SETTINGS, 16'h0001);
    rdchk("settings", REG_SETTINGS, 16'h0001);
    host_u.reg_wr(REG_UPPER, 16'h197f);
    rdchk("upper", REG_UPPER, 16'h1900);
    host_u.reg_wr(REG_LOWER, 16'h14ff);
    rdchk("lower", REG_LOWER, 16'h1480);
    host_u.reg_wr(REG_READING, 16'h1234);
    rdchk("reading", REG_READING, 16'h0000);
    rdchk("unmapped", 3'h5, 16'h0000);
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      #1;
      if (converting) n++;
    end
    check("halted", 16'(n), 16'h0000);
    done_test("shutdown access");

    // Each resolution: its conversion length and its reading mask.
    set_temp(16'h12ff);
    for (int r = 0; r < 4; r++) begin
      s = 8'(r << 5);
      host_u.shot(s, n);
      check("conv time", 16'(n), 16'(CONV << r));
      rdchk("reading", REG_READING, 16'h12ff & (16'hffff << (7 - r)));
      rdchk("settings", REG_SETTINGS, {8'h00, s | 8'h01});
    end
    done_test("resolution");

    // Comparator, active low: every queue depth, then clearing.
    for (int q = 0; q < 4; q++) begin
      s = 8'(q << 3);
      set_temp(16'h2000);
      for (int k = 1; k <= qdep[q]; k++) begin
        host_u.shot(s, n);
        chk_alert(k != qdep[q]);
      end
      set_temp(16'h1000);
      host_u.shot(s, n);
      chk_alert(1'b0);
      host_u.reg_wr(REG_SETTINGS, {8'h00, s});
      repeat (20) @(posedge core_clk);
      #1;
      if (q == 3)
        chk_alert(1'b0);
      repeat (80) @(posedge core_clk);
      #1;
      chk_alert(1'b1);
      host_u.reg_wr(REG_SETTINGS, {8'h00, s | 8'h01});
    end
    done_test("comparator");

    // Interrupt mode, active high.
    s = 8'h06;
    set_temp(16'h2000);
    host_u.shot(s, n);
    chk_alert(1'b1);
    host_u.reg_rd(REG_POINTER, v);
    @(posedge core_clk);
    #1;
    chk_alert(1'b0);
    host_u.shot(s, n);
    chk_alert(1'b0);
    set_temp(16'h1000);
    host_u.shot(s, n);
    chk_alert(1'b1);
    host_u.reg_rd(3'h6, v);
    @(posedge core_clk);
    #1;
    chk_alert(1'b0);
    set_temp(16'h2000);
    host_u.shot(s, n);
    chk_alert(1'b1);
    host_u.reg_wr(REG_SETTINGS, 16'h0006);
    host_u.reg_wr(REG_SETTINGS, 16'h0007);
    @(posedge core_clk);
    #1;
    chk_alert(1'b0);
    done_test("interrupt");

    // Single-shot without shutdown is ignored and conversion runs on.
    host_u.reg_wr(REG_SETTINGS, 16'h0080);
    repeat (3 * CONV) @(posedge core_clk);
    #1;
    check("continuous", {15'h0000, converting}, 16'h0001);
    rdchk("settings", REG_SETTINGS, 16'h0080);
    done_test("ignored shot");
    stop_test();
  end

endmodule : test_temp_sensor_config_alert
